//--- common/xdapc_regs.vh
// xdapc_regs.vh: register offsets, field positions, reset values and mode codes
// for the external data address and pin claim block.
// assumes the processor core's special register bus (8-bit address, 8-bit data).
`ifndef XDAPC_REGS_VH
`define XDAPC_REGS_VH

// ============================================================
// register offsets on the special register bus
`define XDAPC_PAGE_SELECT_ADDR   8'hAA
`define XDAPC_CONFIG_ADDR        8'hC7
`define XDAPC_PTR_HIGH_ADDR      8'h83
`define XDAPC_PTR_LOW_ADDR       8'h82

// ============================================================
// reset values
`define XDAPC_PAGE_SELECT_RESET  8'h00
`define XDAPC_CONFIG_RESET       5'h03
`define XDAPC_PTR_RESET          8'h00

// ============================================================
// configuration field layout
`define XDAPC_CFG_MUX_BIT        4
`define XDAPC_CFG_MODE_HI        3
`define XDAPC_CFG_MODE_LO        2
`define XDAPC_CFG_TIMING_HI      1
`define XDAPC_CFG_TIMING_LO      0
`define XDAPC_CFG_WIDTH          5

// ============================================================
// memory mode codes
`define XDAPC_MODE_ONCHIP        2'h0
`define XDAPC_MODE_SPLIT_NOBANK  2'h1
`define XDAPC_MODE_SPLIT_BANK    2'h2
`define XDAPC_MODE_OFFCHIP       2'h3

// ============================================================
// sizes and pin timing
`define XDAPC_RAM_DEPTH          256
`define XDAPC_RAM_TOP            8'hFF
`define XDAPC_ONCHIP_HIGH        8'h00
`define XDAPC_STROBE_CYCLES      3'h3

`endif

//--- rtl/xdapc_top.v
// xdapc_top.v: forms the external-move effective address, holds the 256-byte
// on-chip external data RAM and claims the port pins for off-chip accesses.
// assumes a core that issues one access request pulse and waits for done.
//
// How it works
// - 256 bytes of on-chip RAM live in the external data space
// - the 8-bit form takes the address high byte from the page select register
// - the 8-bit form takes the low byte from R0 or R1 as named
// - the 16-bit form uses the whole data pointer as the address
// - the data pointer is readable and writable as high and low bytes
// - after reset (memory mode 00) external moves target the 256-byte on-chip RAM
// - pins are claimed only while an off-chip external move executes
// - when the off-chip move ends, pins return to the port latches
// - data pin drivers are off while the read strobe of an off-chip read is low
// - open-drain or push-pull mode is never touched by this block
// - both multiplexed and non-multiplexed bus arrangements are supported
// - four memory modes: on-chip, split, split with bank, off-chip
// - page value n maps 8-bit accesses to n*256 through n*256+255
// - memory mode 00 sends every access on chip, aliasing addresses
// - mux select set means separate address and data pins
`timescale 1ns/10ps
`include "xdapc_regs.vh"

module xdapc_top
(
  input  wire        clk_in,          // system clock, 200 MHz
  input  wire        rst_in,          // asynchronous reset, active high
  input  wire        reg_wr_in,       // special register write strobe
  input  wire        reg_rd_in,       // special register read strobe
  input  wire [7:0]  reg_addr_in,     // special register address
  input  wire [7:0]  reg_wdata_in,    // special register write data
  output reg  [7:0]  reg_rdata_out,   // special register read data
  input  wire        acc_req_in,      // external move request pulse
  input  wire        acc_write_in,    // 1 write, 0 read
  input  wire        acc_form16_in,   // 1 data pointer form, 0 index form
  input  wire [7:0]  acc_index_in,    // contents of the named R0 or R1
  input  wire [7:0]  acc_wdata_in,    // byte to write
  output reg  [7:0]  acc_rdata_out,   // byte read
  output reg         acc_done_out,    // one-cycle pulse at access end
  output reg  [15:0] eff_addr_out,    // effective address of the current access
  input  wire [7:0]  port_latch_ad_in,   // port latch values of address/data pins
  input  wire [7:0]  port_latch_ah_in,   // port latch values of high address pins
  input  wire [7:0]  port_latch_al_in,   // port latch values of low address pins
  input  wire [7:0]  pin_data_in,     // data pins as seen on the package
  output reg         pins_claimed_out,   // interface owns the port pins
  output reg  [7:0]  pin_ad_out,      // address/data pin drive value
  output reg  [7:0]  pin_ad_oe_out,   // address/data pin drive enables
  output reg  [7:0]  pin_ah_out,      // high address pin value
  output reg  [7:0]  pin_al_out,      // low address pin value (non-multiplexed)
  output reg         pin_ale_out,     // address latch enable
  output reg         pin_rd_n_out,    // read strobe, active low
  output reg         pin_wr_n_out     // write strobe, active low
);

  // ============================================================
  // state codes
  localparam ST_IDLE  = 3'h0;
  localparam ST_ALE   = 3'h1;
  localparam ST_STRB  = 3'h2;
  localparam ST_DONE  = 3'h3;

  reg [7:0]  page_high_byte;
  reg [7:0]  pointer_high_byte;
  reg [7:0]  pointer_low_byte;
  reg [`XDAPC_CFG_WIDTH-1:0] ext_mem_config;
  reg [7:0]  onchip_ram [0:`XDAPC_RAM_DEPTH-1];
  reg [2:0]  state;
  reg [2:0]  strobe_cnt;
  reg        cur_write;
  reg [7:0]  cur_wdata;
  reg [7:0]  din_s1;
  reg [7:0]  din_s2;

  wire       bus_mux_select     = ext_mem_config[`XDAPC_CFG_MUX_BIT];
  wire [1:0] memory_mode_select = ext_mem_config[`XDAPC_CFG_MODE_HI:`XDAPC_CFG_MODE_LO];

  // ============================================================
  // address forming and on/off-chip decision
  // effective address from the selected move form
  function [15:0] xdapc_eff_addr;
    input        form16;
    input [15:0] ptr;
    input [7:0]  page;
    input [7:0]  index;
    begin
      if (form16)
        xdapc_eff_addr = ptr;
      else
        xdapc_eff_addr = {page, index};
    end
  endfunction

  // resolves an address to off chip under the memory mode
  function xdapc_is_offchip;
    input [1:0]  mode;
    input [15:0] addr;
    begin
      case (mode)
        `XDAPC_MODE_ONCHIP:       xdapc_is_offchip = 1'b0;
        `XDAPC_MODE_SPLIT_NOBANK,
        `XDAPC_MODE_SPLIT_BANK:   xdapc_is_offchip = (addr[15:8] != `XDAPC_ONCHIP_HIGH);
        `XDAPC_MODE_OFFCHIP:      xdapc_is_offchip = 1'b1;
        default:                  xdapc_is_offchip = 1'b0;
      endcase
    end
  endfunction

  wire [15:0] next_addr = xdapc_eff_addr(acc_form16_in, {pointer_high_byte, pointer_low_byte},
                                         page_high_byte, acc_index_in);
  wire        next_off  = xdapc_is_offchip(memory_mode_select, next_addr);

  // ============================================================
  // data pin synchroniser, pins come from outside the clock domain
  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      din_s1 <= 8'h00;
      din_s2 <= 8'h00;
    end
    else
    begin
      din_s1 <= pin_data_in;
      din_s2 <= din_s1;
    end
  end

  // ============================================================
  // special registers; writes during an access still land
  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      page_high_byte    <= `XDAPC_PAGE_SELECT_RESET;
      pointer_high_byte <= `XDAPC_PTR_RESET;
      pointer_low_byte  <= `XDAPC_PTR_RESET;
      ext_mem_config    <= `XDAPC_CONFIG_RESET;
    end
    else if (reg_wr_in)
    begin
      case (reg_addr_in)
        `XDAPC_PAGE_SELECT_ADDR: page_high_byte    <= reg_wdata_in;
        `XDAPC_PTR_HIGH_ADDR:    pointer_high_byte <= reg_wdata_in;
        `XDAPC_PTR_LOW_ADDR:     pointer_low_byte  <= reg_wdata_in;
        `XDAPC_CONFIG_ADDR:      ext_mem_config    <= reg_wdata_in[`XDAPC_CFG_WIDTH-1:0];
        default:                 ext_mem_config    <= ext_mem_config;
      endcase
    end
  end

  // register read data; unused config bits read zero
  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      reg_rdata_out <= 8'h00;
    else if (reg_rd_in)
    begin
      case (reg_addr_in)
        `XDAPC_PAGE_SELECT_ADDR: reg_rdata_out <= page_high_byte;
        `XDAPC_PTR_HIGH_ADDR:    reg_rdata_out <= pointer_high_byte;
        `XDAPC_PTR_LOW_ADDR:     reg_rdata_out <= pointer_low_byte;
        `XDAPC_CONFIG_ADDR:      reg_rdata_out <= {3'h0, ext_mem_config};
        default:                 reg_rdata_out <= 8'h00;
      endcase
    end
  end

  // ============================================================
  // on-chip RAM; low byte only, so every page aliases onto it
  always @(posedge clk_in)
  begin
    if (acc_req_in && (state == ST_IDLE) && !next_off && acc_write_in)
      onchip_ram[next_addr[7:0]] <= acc_wdata_in;
  end

  // ============================================================
  // access sequencer and pin ownership
  // only drive enables are steered here; open-drain/push-pull stays with the port
  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state            <= ST_IDLE;
      strobe_cnt       <= 3'h0;
      cur_write        <= 1'b0;
      cur_wdata        <= 8'h00;
      acc_rdata_out    <= 8'h00;
      acc_done_out     <= 1'b0;
      eff_addr_out     <= 16'h0000;
      pins_claimed_out <= 1'b0;
      pin_ad_out       <= 8'h00;
      pin_ad_oe_out    <= 8'h00;
      pin_ah_out       <= 8'h00;
      pin_al_out       <= 8'h00;
      pin_ale_out      <= 1'b0;
      pin_rd_n_out     <= 1'b1;
      pin_wr_n_out     <= 1'b1;
    end
    else
    begin
      acc_done_out <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          // idle pins follow the port latches
          pins_claimed_out <= 1'b0;
          pin_ad_out       <= port_latch_ad_in;
          pin_ad_oe_out    <= 8'hFF;
          pin_ah_out       <= port_latch_ah_in;
          pin_al_out       <= port_latch_al_in;
          pin_ale_out      <= 1'b0;
          pin_rd_n_out     <= 1'b1;
          pin_wr_n_out     <= 1'b1;
          if (acc_req_in)
          begin
            eff_addr_out <= next_addr;
            cur_write    <= acc_write_in;
            cur_wdata    <= acc_wdata_in;
            if (next_off)
            begin
              // claim pins only for an off-chip move
              pins_claimed_out <= 1'b1;
              pin_ah_out       <= next_addr[15:8];
              pin_ad_oe_out    <= 8'hFF;
              if (bus_mux_select)
              begin
                // separate pins: address on low pins, data on address/data pins at once
                pin_al_out <= next_addr[7:0];
                pin_ad_out <= acc_wdata_in;
                state      <= ST_STRB;
              end
              else
              begin
                // shared pins: low address first with latch enable
                pin_ad_out  <= next_addr[7:0];
                pin_ale_out <= 1'b1;
                state       <= ST_ALE;
              end
              strobe_cnt <= `XDAPC_STROBE_CYCLES;
            end
            else
            begin
              if (!acc_write_in)
                acc_rdata_out <= onchip_ram[next_addr[7:0]];
              state <= ST_DONE;
            end
          end
        end
        ST_ALE:
        begin
          pin_ale_out <= 1'b0;
          pin_ad_out  <= cur_wdata;
          state       <= ST_STRB;
        end
        ST_STRB:
        begin
          // read releases data drivers so the device can drive
          pin_ad_oe_out <= cur_write ? 8'hFF : 8'h00;
          pin_rd_n_out  <= cur_write;
          pin_wr_n_out  <= !cur_write;
          if (strobe_cnt == 3'h0)
          begin
            acc_rdata_out <= din_s2;
            pin_rd_n_out  <= 1'b1;
            pin_wr_n_out  <= 1'b1;
            state         <= ST_DONE;
          end
          else
            strobe_cnt <= strobe_cnt - 3'h1;
        end
        ST_DONE:
        begin
          // access complete, hand pins back next cycle
          acc_done_out     <= 1'b1;
          pins_claimed_out <= 1'b0;
          pin_ad_oe_out    <= 8'hFF;
          pin_ad_out       <= port_latch_ad_in;
          pin_ah_out       <= port_latch_ah_in;
          pin_al_out       <= port_latch_al_in;
          state            <= ST_IDLE;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

endmodule

//--- test/tb_xdata_address_and_pin_claim.sv
// tb_xdata_address_and_pin_claim.sv: self-checking bench for xdapc_top
// assumes the off-chip memory model on the pins; latches parked high
`timescale 1ns/10ps
`include "xdapc_regs.vh"
module tb_xdata_address_and_pin_claim;
  logic        clk_in = 0, rst_in = 1, reg_wr = 0, reg_rd = 0, req = 0, wr = 0, f16 = 0, mux = 0;
  logic [7:0]  raddr = 0, wdat = 0, idx = 0, awd = 0, rdata, ardata, ad, oe, ah, al, pdata;
  logic [7:0]  latch = 8'hFF;
  logic        done, clm, ale, rdn, wrn;
  logic [15:0] ea;
  logic [7:0]  rd;
  logic        c, a;
  int          mismatches = 0, n_tests = 0, cyc = 0, n;
  // ============================================================
  // clock, timeout and instances
  always #2.5 clk_in = ~clk_in;
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      mismatches++;
      test_done;
    end
  end
  xdapc_top u_dut (.clk_in(clk_in), .rst_in(rst_in), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_addr_in(raddr), .reg_wdata_in(wdat), .reg_rdata_out(rdata), .acc_req_in(req),
    .acc_write_in(wr), .acc_form16_in(f16), .acc_index_in(idx), .acc_wdata_in(awd),
    .acc_rdata_out(ardata), .acc_done_out(done), .eff_addr_out(ea), .port_latch_ad_in(latch),
    .port_latch_ah_in(latch), .port_latch_al_in(latch), .pin_data_in(pdata),
    .pins_claimed_out(clm), .pin_ad_out(ad), .pin_ad_oe_out(oe), .pin_ah_out(ah),
    .pin_al_out(al), .pin_ale_out(ale), .pin_rd_n_out(rdn), .pin_wr_n_out(wrn));
  xdapc_mem_model u_mem (.clk_in(clk_in), .mux_in(mux), .ale_in(ale), .rd_n_in(rdn),
    .wr_n_in(wrn), .ad_in(ad), .ah_in(ah), .al_in(al), .data_out(pdata));
  // ============================================================
  // shared tasks
  task chk(input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e)
    begin
      mismatches++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task reg_w(input logic [7:0] ad_v, input logic [7:0] d);
    @(negedge clk_in);
    {raddr, wdat, reg_wr} = {ad_v, d, 1'b1};
    @(negedge clk_in);
    reg_wr = 0;
  endtask
  task reg_r(input logic [7:0] ad_v, input logic [7:0] e);
    @(negedge clk_in);
    {raddr, reg_rd} = {ad_v, 1'b1};
    @(negedge clk_in);
    reg_rd = 0;
    chk(rdata, e);
  endtask
  // waits for done under a bound, noting claim and latch pulses seen
  task acc(input logic w, input logic f, input logic [7:0] i, input logic [7:0] d);
    @(negedge clk_in);
    {wr, f16, idx, awd, req} = {w, f, i, d, 1'b1};
    @(negedge clk_in);
    {req, c, a, n} = {1'b0, 1'b0, 1'b0, 32'd1};
    while (done !== 1'b1 && n < 20)
    begin
      c |= clm;
      a |= ale;
      @(negedge clk_in);
      n++;
    end
    rd = ardata;
  endtask
  // ============================================================
  // scenarios
  task t_regs;
    reg_r(8'hAA, 8'h00);
    reg_r(`XDAPC_CONFIG_ADDR, 8'h03);
    reg_r(`XDAPC_PTR_HIGH_ADDR, 8'h00);
    reg_w(`XDAPC_PTR_HIGH_ADDR, 8'h12);
    reg_w(`XDAPC_PTR_LOW_ADDR, 8'h34);
    reg_r(`XDAPC_PTR_HIGH_ADDR, 8'h12);
    reg_r(`XDAPC_PTR_LOW_ADDR, 8'h34);
    reg_w(`XDAPC_CONFIG_ADDR, 8'hE3);
    reg_r(`XDAPC_CONFIG_ADDR, 8'h03);
    reg_w(8'h55, 8'h77);
    reg_r(8'h55, 8'h00);
    $display("t_regs done");
  endtask
  task t_onchip;
    acc(1, 1, 8'h00, 8'hA5);
    chk(ea, 16'h1234);
    chk(16'(n), 2);
    chk(c, 0);
    reg_w(8'hAA, 8'h77);
    acc(0, 0, 8'h34, 8'h00);
    chk(ea, 16'h7734);
    chk(rd, 8'hA5);
    $display("t_onchip done");
  endtask
  task t_modes;
    for (int m = 0; m < 4; m++)
      for (int h = 0; h < 2; h++)
      begin
        reg_w(`XDAPC_CONFIG_ADDR, 8'(8'h03 | (m << 2)));
        reg_w(8'hAA, h ? 8'h05 : 8'h00);
        acc(1, 0, 8'h10, 8'h3C);
        chk(c, m == 3 || (m != 0 && h != 0));
        chk(16'(n), c ? 7 : 2);
      end
    $display("t_modes done");
  endtask
  task t_offmux;
    reg_w(`XDAPC_CONFIG_ADDR, 8'h0F);
    reg_w(8'hAA, 8'h01);
    acc(1, 0, 8'h80, 8'h5A);
    acc(0, 0, 8'h80, 8'h00);
    chk(ea, 16'h0180);
    chk(rd, 8'h5A);
    chk(a, 1);
    chk(16'(n), 7);
    $display("t_offmux done");
  endtask
  task t_nonmux;
    mux = 1;
    reg_w(`XDAPC_CONFIG_ADDR, 8'h1F);
    reg_w(`XDAPC_PTR_HIGH_ADDR, 8'hBE);
    reg_w(`XDAPC_PTR_LOW_ADDR, 8'hEF);
    acc(1, 1, 8'h00, 8'hC3);
    acc(0, 1, 8'h00, 8'h00);
    chk(ea, 16'hBEEF);
    chk(rd, 8'hC3);
    chk(a, 0);
    chk(16'(n), 6);
    chk({oe, ad}, 16'hFFFF);
    $display("t_nonmux done");
  endtask
  // ============================================================
  // verdict and main sequence
  task test_done;
    $display("compares %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(negedge clk_in);
    rst_in = 0;
    t_regs;
    t_onchip;
    t_modes;
    t_offmux;
    t_nonmux;
    test_done;
  end
endmodule

//--- test/xdapc_assertions.sv
// xdapc_assertions.sv: port checker for the pin claim and access timing
// assumes it is bound onto xdapc_top and sees only that module's ports
`timescale 1ns/10ps
// ============================================================
// checker
module xdapc_chk
(
  input logic        clk_in,           // system clock
  input logic        rst_in,           // reset, active high
  input logic        acc_done_out,     // access end pulse
  input logic        pins_claimed_out, // pin ownership
  input logic [7:0]  pin_ad_out,       // address/data drive
  input logic [7:0]  pin_ad_oe_out,    // drive enables
  input logic [7:0]  pin_ah_out,       // high address pins
  input logic [7:0]  port_latch_ad_in, // parked latch values
  input logic [15:0] eff_addr_out,     // effective address
  input logic        pin_rd_n_out,     // read strobe
  input logic        pin_wr_n_out      // write strobe
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // a read strobe must end within 5 cycles of falling, never hang the bus
  sequence rd_low_s; $fell(pin_rd_n_out); endsequence
  sequence rd_end_s; ##[1:5] pin_rd_n_out; endsequence
  rd_claim_a: assert property (!pin_rd_n_out |-> pins_claimed_out)
    else $error("read strobe without pin claim");
  wr_claim_a: assert property (!pin_wr_n_out |-> pins_claimed_out)
    else $error("write strobe without pin claim");
  read_oe_off_a: assert property (!pin_rd_n_out |-> pin_ad_oe_out == 8'h00)
    else $error("data drivers on during read");
  // pins read zero during reset, so the first edge after release is not yet latch driven
  latch_follow_a: assert property (!$past(rst_in) && !pins_claimed_out && !$past(pins_claimed_out) |->
    pin_ad_out == $past(port_latch_ad_in) && pin_ad_oe_out == 8'hFF)
    else $error("idle pins not under latch control");
  claim_end_done_a: assert property ($fell(pins_claimed_out) |-> acc_done_out)
    else $error("claim released away from done");
  claim_addr_a: assert property ($rose(pins_claimed_out) |-> pin_ah_out == eff_addr_out[15:8])
    else $error("high address pins wrong");
  done_pulse_a: assert property (acc_done_out |=> !acc_done_out)
    else $error("done longer than one cycle");
  rd_strobe_end_a: assert property (rd_low_s |-> rd_end_s)
    else $error("read strobe never ends");
endmodule
bind xdapc_top xdapc_chk u_chk (.clk_in, .rst_in, .acc_done_out, .pins_claimed_out, .pin_ad_out,
  .pin_ad_oe_out, .pin_ah_out, .port_latch_ad_in, .eff_addr_out, .pin_rd_n_out, .pin_wr_n_out);

//--- test/xdapc_mem_model.sv
// xdapc_mem_model.sv: behavioural off-chip data memory on the interface pins
// assumes registered strobes; no pull on data lines
`timescale 1ns/10ps
// ============================================================
// model
module xdapc_mem_model
(
  input  logic       clk_in,  // system clock
  input  logic       mux_in,  // 1 separate address pins
  input  logic       ale_in,  // address latch enable
  input  logic       rd_n_in, // read strobe, active low
  input  logic       wr_n_in, // write strobe, active low
  input  logic [7:0] ad_in,   // address/data pins
  input  logic [7:0] ah_in,   // high address pins
  input  logic [7:0] al_in,   // low address pins
  output logic [7:0] data_out // data pins seen by the chip
);
  logic [7:0]  mem [0:65535];
  logic [7:0]  lo_latch = 8'h00;
  logic [7:0]  last     = 8'h00;
  logic [15:0] addr;
  // muxed bus needs the low byte held from the latch pulse
  assign addr = {ah_in, mux_in ? al_in : lo_latch};
  // released bus shows the inverse of its last value, not a stale copy
  assign data_out = !rd_n_in ? mem[addr] : ~last;
  always @(posedge clk_in)
  begin
    if (ale_in) lo_latch <= ad_in;
    if (!wr_n_in) mem[addr] <= ad_in;
    if (!rd_n_in) last <= data_out;
  end
endmodule
